/* File: sra_regs.svh */
// constants for the shared ram arbiter
`ifndef SRA_REGS_SVH
`define SRA_REGS_SVH

// semaphore layout
`define SRA_SEM_WIDTH       2
`define SRA_SEM_HOST_BIT    0
`define SRA_SEM_LOCAL_BIT   1
`define SRA_SEM_RESET       2'h0

// synchroniser depth for pins from the host side
`define SRA_SYNC_DEPTH      2

// number of host pins that carry one-shot events
`define SRA_EVENT_PINS      2
`define SRA_EVT_ACK         0
`define SRA_EVT_IRQ_IN      1

// idle levels of the active-low strobes and enables, and of the active-high latch enable
`define SRA_STROBE_IDLE     1'h1
`define SRA_LATCH_IDLE      1'h0

`endif

/* File: sra_pkg.sv */
// types for the shared ram arbiter
package sra_pkg;

	// grant owner of the shared ram, one-hot
	typedef enum logic [2:0] {
		SRA_IDLE  = 3'h1,
		SRA_HOST  = 3'h2,
		SRA_LOCAL = 3'h4
	} sra_state_t;

	// set of ram side strobes produced for one granted cycle
	typedef struct packed {
		logic addr_en_n;
		logic data_bus_en_n;
		logic latch_en;
		logic latch_out_en_n;
		logic write_strobe_n;
		logic output_en_n;
	} sra_strobes_t;

endpackage : sra_pkg

/* File: sra_arbiter.sv */
// shared ram arbiter with host/local strobes and interrupt semaphore
//
// How it works
// - host request drives host address enable low
// - host write drives host data enable low
// - host read opens host data latch
// - host read enables host latch output
// - direction picks ram write strobe or output
// - host acknowledge pulse clears semaphore bit 0
// - host interrupt pulse sets bit 1, local irq
// - local write of bit 0 raises host irq
// - host ready pulled low during host request
// - host request synchronised on falling edges
// - sampled host request drives ram select low
// - local request drives local address enable low
// - local write drives local data enable low
// - local read opens local data latch
// - local read enables local latch output
// - local write of zero drops local irq
// - local ready low while a local request waits on host ownership
// - local request sampled on falling edges
// - ram select low for either granted cycle
`include "sra_regs.svh"

module sra_arbiter (
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	// host side pins, asynchronous to clock
	input  wire logic                        host_ram_request,
	input  wire logic                        host_write_not_read,
	input  wire logic                        host_irq_ack,
	input  wire logic                        host_to_local_irq_in,
	output logic                             host_addr_bus_en_n,
	output logic                             host_data_bus_en_n,
	output logic                             host_data_latch_en,
	output logic                             host_latch_out_en_n,
	output logic                             host_irq_out,
	input  wire logic                        host_ready_in,
	output logic                             host_ready_out,
	output logic                             host_ready_oe,
	// local side pins, synchronous to clock
	input  wire logic                        local_ram_request_n,
	input  wire logic                        local_write_not_read,
	output logic                             local_addr_bus_en_n,
	output logic                             local_data_bus_en_n,
	output logic                             local_data_latch_en,
	output logic                             local_latch_out_en_n,
	output logic                             local_irq_out,
	input  wire logic                        local_ready_in,
	output logic                             local_ready_out,
	output logic                             local_ready_oe,
	// local semaphore write strobe and read back
	input  wire logic                        local_sem_write,
	input  wire logic [`SRA_SEM_WIDTH-1:0]   local_sem_wdata,
	output logic      [`SRA_SEM_WIDTH-1:0]   local_sem_rdata,
	// shared ram strobes
	output logic                             ram_select_n,
	output logic                             ram_output_en_n,
	output logic                             ram_write_strobe_n
);

	////////////////////////////////////////////////////////////////////////
	// decode of one side's strobes from its direction
	function automatic sra_pkg::sra_strobes_t strobes_for(
		input logic owned,
		input logic write_not_read
	);
		sra_pkg::sra_strobes_t s;
		s.addr_en_n      = `SRA_STROBE_IDLE;
		s.data_bus_en_n  = `SRA_STROBE_IDLE;
		s.latch_en       = `SRA_LATCH_IDLE;
		s.latch_out_en_n = `SRA_STROBE_IDLE;
		s.write_strobe_n = `SRA_STROBE_IDLE;
		s.output_en_n    = `SRA_STROBE_IDLE;
		if (owned) begin
			s.addr_en_n = 1'b0;
			if (write_not_read) begin
				s.data_bus_en_n  = 1'b0;
				s.write_strobe_n = 1'b0;
			end else begin
				s.latch_en       = 1'b1;
				s.latch_out_en_n = 1'b0;
				s.output_en_n    = 1'b0;
			end
		end
		return s;
	endfunction : strobes_for

	////////////////////////////////////////////////////////////////////////
	// request sampling on the falling edge
	logic [`SRA_SYNC_DEPTH-1:0] host_req_sync_reg;
	logic                       local_req_n_reg;
	logic                       host_req_s;
	logic                       local_req_s;

	// host request is asynchronous, so two falling-edge flops
	always_ff @(negedge clock or negedge rst_b) begin
		if (!rst_b) begin
			host_req_sync_reg <= '0;
		end else begin
			host_req_sync_reg <= {host_req_sync_reg[0], host_ram_request};
		end
	end

	// local request is already synchronous; one sample is enough
	always_ff @(negedge clock or negedge rst_b) begin
		if (!rst_b) begin
			local_req_n_reg <= 1'b1;
		end else begin
			local_req_n_reg <= local_ram_request_n;
		end
	end

	assign host_req_s  = host_req_sync_reg[`SRA_SYNC_DEPTH-1];
	assign local_req_s = !local_req_n_reg;

	////////////////////////////////////////////////////////////////////////
	// host direction, held through two flops
	logic [`SRA_SYNC_DEPTH-1:0] host_dir_sync_reg;
	logic                       host_dir_s;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			host_dir_sync_reg <= '0;
		end else begin
			host_dir_sync_reg <= {host_dir_sync_reg[0], host_write_not_read};
		end
	end

	assign host_dir_s = host_dir_sync_reg[`SRA_SYNC_DEPTH-1];

	////////////////////////////////////////////////////////////////////////
	// event pins: synchronise, then rising edge gives a one-cycle pulse
	logic [`SRA_EVENT_PINS-1:0] evt_pin;
	logic [`SRA_EVENT_PINS-1:0] evt_pulse;
	assign evt_pin[`SRA_EVT_ACK]    = host_irq_ack;
	assign evt_pin[`SRA_EVT_IRQ_IN] = host_to_local_irq_in;

	generate
		for (genvar i = 0; i < `SRA_EVENT_PINS; i++) begin : g_evt
			logic [`SRA_SYNC_DEPTH:0] evt_sync_reg;
			// the third stage only feeds the edge detector
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					evt_sync_reg <= '0;
				end else begin
					evt_sync_reg <= {evt_sync_reg[`SRA_SYNC_DEPTH-1:0],
						evt_pin[i]};
				end
			end
			assign evt_pulse[i] = evt_sync_reg[`SRA_SYNC_DEPTH-1] &
				!evt_sync_reg[`SRA_SYNC_DEPTH];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// grant state machine
	sra_pkg::sra_state_t state_reg;
	sra_pkg::sra_state_t state_next;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sra_pkg::SRA_IDLE: begin
				// host wins a tie so its slow, asynchronous cycle is not held off
				if (host_req_s) begin
					state_next = sra_pkg::SRA_HOST;
				end else if (local_req_s) begin
					state_next = sra_pkg::SRA_LOCAL;
				end
			end
			sra_pkg::SRA_HOST: begin
				if (!host_req_s) begin
					state_next = sra_pkg::SRA_IDLE;
				end
			end
			sra_pkg::SRA_LOCAL: begin
				if (!local_req_s) begin
					state_next = sra_pkg::SRA_IDLE;
				end
			end
			default: begin
				state_next = sra_pkg::SRA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= sra_pkg::SRA_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strobes, registered from the next grant
	sra_pkg::sra_strobes_t host_s;
	sra_pkg::sra_strobes_t local_s;
	logic                  host_own;
	logic                  local_own;
	assign host_own  = (state_next == sra_pkg::SRA_HOST);
	assign local_own = (state_next == sra_pkg::SRA_LOCAL);
	assign host_s    = strobes_for(host_own, host_dir_s);
	assign local_s   = strobes_for(local_own, local_write_not_read);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			host_addr_bus_en_n  <= `SRA_STROBE_IDLE;
			host_data_bus_en_n  <= `SRA_STROBE_IDLE;
			host_data_latch_en  <= `SRA_LATCH_IDLE;
			host_latch_out_en_n <= `SRA_STROBE_IDLE;
		end else begin
			host_addr_bus_en_n  <= host_s.addr_en_n;
			host_data_bus_en_n  <= host_s.data_bus_en_n;
			host_data_latch_en  <= host_s.latch_en;
			host_latch_out_en_n <= host_s.latch_out_en_n;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			local_addr_bus_en_n  <= `SRA_STROBE_IDLE;
			local_data_bus_en_n  <= `SRA_STROBE_IDLE;
			local_data_latch_en  <= `SRA_LATCH_IDLE;
			local_latch_out_en_n <= `SRA_STROBE_IDLE;
		end else begin
			local_addr_bus_en_n  <= local_s.addr_en_n;
			local_data_bus_en_n  <= local_s.data_bus_en_n;
			local_data_latch_en  <= local_s.latch_en;
			local_latch_out_en_n <= local_s.latch_out_en_n;
		end
	end

	// only one side is ever owned, so and-ing the lows merges them safely
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ram_select_n       <= `SRA_STROBE_IDLE;
			ram_write_strobe_n <= `SRA_STROBE_IDLE;
			ram_output_en_n    <= `SRA_STROBE_IDLE;
		end else begin
			ram_select_n       <= !(host_own || local_own);
			ram_write_strobe_n <= host_s.write_strobe_n &
				local_s.write_strobe_n;
			ram_output_en_n    <= host_s.output_en_n &
				local_s.output_en_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// open-drain ready pins; the pin levels are not read back
	assign host_ready_out  = 1'b0;
	assign local_ready_out = 1'b0;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			host_ready_oe  <= 1'b0;
			local_ready_oe <= 1'b0;
		end else begin
			host_ready_oe  <= host_req_s;
			local_ready_oe <= local_req_s &&
				(state_next == sra_pkg::SRA_HOST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// semaphore; a hardware set beats a clear in the same cycle
	logic sem_host_reg;
	logic sem_local_reg;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sem_host_reg <= 1'b0;
		end else if (local_sem_write &&
				local_sem_wdata[`SRA_SEM_HOST_BIT]) begin
			sem_host_reg <= 1'b1;
		end else if (evt_pulse[`SRA_EVT_ACK] || local_sem_write) begin
			sem_host_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sem_local_reg <= 1'b0;
		end else if (evt_pulse[`SRA_EVT_IRQ_IN]) begin
			sem_local_reg <= 1'b1;
		end else if (local_sem_write &&
				!local_sem_wdata[`SRA_SEM_LOCAL_BIT]) begin
			sem_local_reg <= 1'b0;
		end
	end

	assign host_irq_out                        = sem_host_reg;
	assign local_irq_out                       = sem_local_reg;
	assign local_sem_rdata[`SRA_SEM_HOST_BIT]  = sem_host_reg;
	assign local_sem_rdata[`SRA_SEM_LOCAL_BIT] = sem_local_reg;
endmodule : sra_arbiter

/* File: sra_host_model.sv */
// host processor model: answers its interrupt with an acknowledge
module sra_host_model (
	input wire logic	clock,
	input wire logic	slow,
	input wire logic	irq,
	output logic		ack
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	initial ack = 1'h0;
	// two-cycle pulse so the synchroniser cannot miss it
	always @(posedge clock) begin
		n <= irq ? n + 1 : 0;
		ack <= #1 (n >= (slow ? 6 : 1)) && (n < (slow ? 8 : 3));
	end
endmodule : sra_host_model

/* File: sra_arbiter_props.sv */
// port checker of the shared ram arbiter
module sra_arbiter_props (
	input wire logic	clock,
	input wire logic	rst_b,
	input wire logic	host_ram_request,
	input wire logic	host_irq_ack,
	input wire logic	host_irq_out,
	input wire logic	host_addr_bus_en_n,
	input wire logic	host_data_bus_en_n,
	input wire logic	host_data_latch_en,
	input wire logic	host_latch_out_en_n,
	input wire logic	local_ram_request_n,
	input wire logic	local_write_not_read,
	input wire logic	local_addr_bus_en_n,
	input wire logic	local_data_bus_en_n,
	input wire logic	local_irq_out,
	input wire logic	local_ready_oe,
	input wire logic	local_sem_write,
	input wire logic [1:0]	local_sem_wdata,
	input wire logic [1:0]	local_sem_rdata,
	input wire logic	ram_select_n,
	input wire logic	ram_output_en_n,
	input wire logic	ram_write_strobe_n
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	a_one_owner: assert property (
		host_addr_bus_en_n | local_addr_bus_en_n) else $error("two owners");
	a_select_owner: assert property (
		ram_select_n == (host_addr_bus_en_n & local_addr_bus_en_n))
		else $error("select differs from owner");
	a_host_dir: assert property (!host_addr_bus_en_n |->
		ram_write_strobe_n == host_data_bus_en_n
		&& ram_output_en_n == host_latch_out_en_n
		&& host_data_latch_en == host_data_bus_en_n)
		else $error("host strobes disagree");
	a_local_dir: assert property (!local_addr_bus_en_n |->
		ram_write_strobe_n == !$past(local_write_not_read)
		&& local_data_bus_en_n == ram_write_strobe_n)
		else $error("local strobes disagree");
	a_held_off: assert property (
		local_ready_oe |-> local_addr_bus_en_n) else $error("ready held");
	a_sem_view: assert property (
		local_sem_rdata == {local_irq_out, host_irq_out})
		else $error("irq outputs differ from semaphore");
	a_irq_set: assert property (
		local_sem_write && local_sem_wdata[0] |=> host_irq_out)
		else $error("host irq not raised");
	a_ack_clear: assert property (
		$rose(host_irq_ack) && !local_sem_write ##1 !local_sem_write[*2]
		|=> !host_irq_out) else $error("ack did not clear");
	a_host_grant: assert property (
		$rose(host_ram_request) && ram_select_n && local_ram_request_n
		|-> ##[1:3] !host_addr_bus_en_n) else $error("host not granted");
	a_local_end: assert property (
		$rose(local_ram_request_n) && !local_addr_bus_en_n
		|=> local_addr_bus_en_n) else $error("local cycle not ended");
	c_host: cover property (!host_addr_bus_en_n);
	c_wait: cover property (local_ready_oe);
	c_ack: cover property ($fell(host_irq_out));
endmodule : sra_arbiter_props
bind sra_arbiter sra_arbiter_props u_props (.*);

/* File: sra_arbiter_tb_top.sv */
// self-checking bench of the shared ram arbiter
module sra_arbiter_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clock = 1'h0, rst_b = 1'h0, slow = 1'h0;
	logic		host_ram_request = 1'h0, host_write_not_read = 1'h0;
	logic		host_irq_ack, host_to_local_irq_in = 1'h0;
	logic		local_ram_request_n = 1'h1, local_write_not_read = 1'h0;
	logic		local_sem_write = 1'h0, host_ready_in, local_ready_in;
	logic [1:0]	local_sem_wdata = 2'h0, local_sem_rdata;
	logic		host_addr_bus_en_n, host_data_bus_en_n, host_data_latch_en;
	logic		host_latch_out_en_n, host_irq_out, host_ready_out;
	logic		host_ready_oe, local_addr_bus_en_n, local_data_bus_en_n;
	logic		local_data_latch_en, local_latch_out_en_n, local_irq_out;
	logic		local_ready_out, local_ready_oe, ram_select_n;
	logic		ram_output_en_n, ram_write_strobe_n;
	logic [9:0]	q[$];
	logic [31:0]	rs = 32'h0000_19f4;
	int		checks = 0, fail_count = 0, cyc = 0;
	wire [9:0]	sv = {host_addr_bus_en_n, host_data_bus_en_n,
		host_data_latch_en, host_latch_out_en_n, local_addr_bus_en_n,
		local_data_bus_en_n, local_data_latch_en, local_latch_out_en_n,
		ram_output_en_n, ram_write_strobe_n};
	wire [5:0]	ob = {host_irq_out, local_irq_out, host_ready_oe,
		local_ready_oe, host_addr_bus_en_n, local_addr_bus_en_n};
	// open-drain ready lines with pull-ups
	assign host_ready_in = host_ready_oe ? host_ready_out : 1'h1;
	assign local_ready_in = local_ready_oe ? local_ready_out : 1'h1;
	sra_arbiter dut (.*);
	sra_host_model hm (.clock, .slow, .irq(host_irq_out), .ack(host_irq_ack));
	always #50 clock = ~clock;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nx(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	function automatic logic [9:0] ev(bit h, bit w);
		logic [3:0] a;
		a = {1'h0, !w, !w, w};
		return h ? {a, 4'hd, w, !w} : {4'hd, a, w, !w};
	endfunction : ev
	task automatic chk(string n, logic [9:0] s, logic [9:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tick;
		@(posedge clock);
		#1;
	endtask : tick
	task automatic wt(string n, int k, logic v);
		for (int i = 0; i < 16 && ob[k] !== v; i++) tick();
		chk(n, {9'h0, ob[k]}, {9'h0, v});
	endtask : wt
	// direction is set a cycle ahead so the host synchroniser has it
	task automatic mem(bit h, bit w, int n);
		q.push_back(ev(h, w));
		if (h) host_write_not_read = w; else local_write_not_read = w;
		tick();
		if (h) host_ram_request = 1'h1; else local_ram_request_n = 1'h0;
		wt("owner", h, 1'h0);
		repeat (n) tick();
		if (h) host_ram_request = 1'h0; else local_ram_request_n = 1'h1;
		wt("release", h, 1'h1);
		tick();
	endtask : mem
	task automatic sem(logic [1:0] d, logic [1:0] e);
		local_sem_write = 1'h1;
		local_sem_wdata = d;
		tick();
		local_sem_write = 1'h0;
		chk("semaphore", {8'h0, local_sem_rdata}, {8'h0, e});
	endtask : sem
	task automatic test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	always @(negedge ram_select_n) begin
		#1;
		chk("strobes", sv, q.size() ? q.pop_front() : 10'h3ff);
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clock);
		#1;
		rst_b = 1'h1;
		tick();
		for (int i = 0; i < 12; i++) begin
			rs = nx(rs);
			mem(rs[0], rs[1], i < 4 ? i : int'(rs[3:2]));
		end
		$display("test cycles done");
		// host synchroniser lags a cycle, so local asks one cycle later
		q.push_back(ev(1, 1));
		q.push_back(ev(0, 0));
		host_write_not_read = 1'h1;
		local_write_not_read = 1'h0;
		tick();
		host_ram_request = 1'h1;
		tick();
		local_ram_request_n = 1'h0;
		wt("host first", 1, 1'h0);
		tick();
		chk("ready", {8'h0, ob[3:2]}, 10'h3);
		chk("ready pins", {8'h0, host_ready_in, local_ready_in}, 10'h0);
		host_ram_request = 1'h0;
		wt("local next", 0, 1'h0);
		chk("host ready", {9'h0, host_ready_oe}, 10'h0);
		chk("host ready pin", {9'h0, host_ready_in}, 10'h1);
		local_ram_request_n = 1'h1;
		wt("local end", 0, 1'h1);
		$display("test tie done");
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			sem(2'h1, 2'h1);
			wt("host irq", 5, 1'h0);
			host_to_local_irq_in = 1'h1;
			tick();
			tick();
			host_to_local_irq_in = 1'h0;
			wt("local irq", 4, 1'h1);
			sem(2'h2, 2'h2);
			sem(2'h0, 2'h0);
		end
		$display("test semaphore done");
		test_done();
	end
endmodule : sra_arbiter_tb_top
